// [hdl/pcp_command_prog.sv]
// command word decode and initialization sequencing front end
//
// Notes on behaviour
// R1: low port, data bit four: starts initialization
// R2: initialization clears edge detection, needs fresh rise
// R3: initialization unmasks all eight channels
// R4: initialization sets lowest priority and identity seven
// R5: initialization cancels special mask, selects pending read
// R6: no fourth command: fourth-command settings forced zero
// R7: low port reads status choice, high reads mask
// R8: high-port stores follow init sequence, then mask
// R9: host sends two to four init bytes first
// R10: spacing selector picks four or eight byte slots
// R11: 16-bit host: upper five address bits plus level
// R12: level trigger disables request edge detection
// R13: lone controller skips the third command
// R14: master: set bits mark slave-equipped inputs
// R15: slave: identity bits compared with cascade inputs
// R16: buffered mode turns pin into buffer enable
// R17: buffered: selector one master, zero slave
// R18: fourth command sets nesting and automatic end
// R19: host type picks 8-bit or 16-bit sequence
// R20: mask command: one inhibits, zero enables channel
// R21: rotate/end: three control bits, three level bits
// R22: special mask bit only acts when enabled
// R23: low port, bit four clear: bit three selects
`timescale 1ns/1ps
module pcp_command_prog
	import pcp_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// host parallel bus
	input wire logic chip_sel_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic port_select_line,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_n,
	// slave-program / buffer-enable pin
	input wire logic spen_in,
	output logic spen_out,
	output logic spen_oe_n,
	// cascade lines
	input wire logic [2:0] cascade_in,
	output logic [2:0] cascade_out,
	output logic cascade_oe_n,
	// state from the priority core
	input wire logic [7:0] pending_request_bits,
	input wire logic [7:0] in_service_bits,
	input wire logic [2:0] ack_level,
	// programmed modes toward the core
	output logic [7:0] channel_mask_bits,
	output logic edge_sense_clear,
	output logic edge_detect_enable,
	output logic level_trigger_sel,
	output logic lone_controller_flag,
	output logic [2:0] lowest_priority_level,
	output logic [2:0] slave_identity,
	output logic [7:0] slave_equipped,
	output logic master_role,
	output logic buffered_mode,
	output logic auto_end_of_service,
	output logic special_nesting_sel,
	output logic host_cpu_type,
	output logic special_mask_mode,
	output logic init_done,
	// rotate/end command toward the core
	output logic rot_end_valid,
	output logic [2:0] rot_end_ctrl,
	output logic [2:0] target_level_bits,
	// acknowledge bytes and cascade decisions
	output logic [7:0] call_byte,
	output logic [7:0] addr_low_byte,
	output logic [7:0] addr_high_byte,
	output logic [7:0] vector16_byte,
	output logic ack_slave_supplies,
	output logic cascade_match
);
	pcp_seq_t seq_state; // initialization sequencer
	pcp_seq_t next_seq_state; // next sequencer state
	pcp_rdsel_t status_read_sel; // status chosen for low-port reads
	logic wr_go; // start of a store strobe
	logic rd_go; // start of a fetch strobe
	logic init_start; // first init command seen
	logic wr_high; // store on the high port
	logic wr_rot_end; // rotate/end command store
	logic wr_special; // special operation command store
	logic fourth_cmd_needed; // fourth command expected
	logic vector_spacing_sel; // call slot spacing
	logic buffer_master_sel; // master/slave selector of command four
	logic poll_armed; // next low-port read returns the level
	logic [2:0] addr_low_base; // address bits 7..5
	logic [7:0] addr_high; // address bits 15..8
	logic [7:0] next_read_data; // byte for the next fetch
	logic [7:0] vf_call; // formatter call byte
	logic [7:0] vf_low; // formatter low address byte
	logic [7:0] vf_high; // formatter high address byte
	logic [7:0] vf_vec16; // formatter 16-bit host byte
	logic ready; // operation commands accepted

	// store and fetch strobe detectors
	pcp_strobe_edge u_wr_edge (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.strobe_n(wr_n),
		.chip_sel_n(chip_sel_n),
		.start(wr_go)
	);

	pcp_strobe_edge u_rd_edge (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.strobe_n(rd_n),
		.chip_sel_n(chip_sel_n),
		.start(rd_go)
	);

	// acknowledge byte builder
	pcp_vector_format u_vec (
		.addr_low_base(addr_low_base),
		.addr_high(addr_high),
		.vector_spacing_sel(vector_spacing_sel),
		.level(ack_level),
		.call_byte(vf_call),
		.addr_low_byte(vf_low),
		.addr_high_byte(vf_high),
		.vector16_byte(vf_vec16)
	);

	// store decode
	assign ready = (seq_state == PCP_READY);
	assign init_start = wr_go & ~port_select_line & data_in[IC1_INIT_MARK]; // R1
	assign wr_high = wr_go & port_select_line;
	// operation commands only count once the series is complete
	assign wr_rot_end = wr_go & ready & ~port_select_line & ~data_in[IC1_INIT_MARK]
		& ~data_in[OC_SPECIAL_MARK]; // R23
	assign wr_special = wr_go & ready & ~port_select_line & ~data_in[IC1_INIT_MARK]
		& data_in[OC_SPECIAL_MARK]; // R23
	assign init_done = ready;
	assign edge_detect_enable = ~level_trigger_sel; // R12

	// sequencer next state; a new first command always restarts
	always_comb begin
		next_seq_state = seq_state;
		if (init_start) begin
			next_seq_state = PCP_EXPECT_TWO; // R1
		end else if (wr_high) begin
			case (seq_state)
				PCP_EXPECT_TWO: begin
					if (!lone_controller_flag) begin
						next_seq_state = PCP_EXPECT_THREE;
					end else if (fourth_cmd_needed) begin
						next_seq_state = PCP_EXPECT_FOUR; // R13
					end else begin
						next_seq_state = PCP_READY; // R13
					end
				end
				PCP_EXPECT_THREE: begin
					next_seq_state = fourth_cmd_needed ? PCP_EXPECT_FOUR : PCP_READY; // R8
				end
				PCP_EXPECT_FOUR: begin
					next_seq_state = PCP_READY; // R8
				end
				default: begin
					next_seq_state = seq_state;
				end
			endcase
		end
	end

	// sequencer register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_state <= PCP_UNINIT;
		end else begin
			seq_state <= next_seq_state;
		end
	end

	// first and second command fields, plus init side effects
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fourth_cmd_needed <= 1'b0;
			lone_controller_flag <= 1'b0;
			vector_spacing_sel <= 1'b0;
			level_trigger_sel <= 1'b0;
			addr_low_base <= LEVEL_ZERO;
			addr_high <= BYTE_ZERO;
			edge_sense_clear <= 1'b0;
			lowest_priority_level <= LEVEL_SEVEN;
		end else begin
			edge_sense_clear <= init_start; // R2
			if (init_start) begin
				fourth_cmd_needed <= data_in[IC1_FOURTH_NEEDED]; // R6
				lone_controller_flag <= data_in[IC1_LONE]; // R13
				vector_spacing_sel <= data_in[IC1_SPACING]; // R10
				level_trigger_sel <= data_in[IC1_LEVEL_TRIG]; // R12
				addr_low_base <= data_in[7:5];
				lowest_priority_level <= LEVEL_SEVEN; // R4
			end else if (wr_high && seq_state == PCP_EXPECT_TWO) begin
				addr_high <= data_in; // R8
			end
		end
	end

	// third command: slave map or own identity
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			slave_equipped <= BYTE_ZERO;
			slave_identity <= LEVEL_SEVEN;
		end else if (init_start) begin
			slave_identity <= LEVEL_SEVEN; // R4
		end else if (wr_high && seq_state == PCP_EXPECT_THREE) begin
			slave_equipped <= data_in; // R14
			slave_identity <= data_in[2:0]; // R15
		end
	end

	// fourth command; zeroed at the first command when it will not come
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_cpu_type <= 1'b0;
			auto_end_of_service <= 1'b0;
			buffer_master_sel <= 1'b0;
			buffered_mode <= 1'b0;
			special_nesting_sel <= 1'b0;
		end else if (init_start && !data_in[IC1_FOURTH_NEEDED]) begin
			host_cpu_type <= 1'b0; // R6
			auto_end_of_service <= 1'b0; // R6
			buffer_master_sel <= 1'b0; // R6
			buffered_mode <= 1'b0; // R6
			special_nesting_sel <= 1'b0; // R6
		end else if (wr_high && seq_state == PCP_EXPECT_FOUR) begin
			host_cpu_type <= data_in[IC4_HOST_TYPE]; // R19
			auto_end_of_service <= data_in[IC4_AUTO_END]; // R18
			buffer_master_sel <= data_in[IC4_MASTER_SEL]; // R17
			buffered_mode <= data_in[IC4_BUFFERED]; // R16
			special_nesting_sel <= data_in[IC4_NESTING]; // R18
		end
	end

	// mask register: cleared by init, loaded by high stores when ready
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			channel_mask_bits <= MASK_CLEAR;
		end else if (init_start) begin
			channel_mask_bits <= MASK_CLEAR; // R3
		end else if (wr_high && ready) begin
			channel_mask_bits <= data_in; // R20
		end
	end

	// rotate/end command handed to the core as a one-cycle pulse
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rot_end_valid <= 1'b0;
			rot_end_ctrl <= LEVEL_ZERO;
			target_level_bits <= LEVEL_ZERO;
		end else begin
			rot_end_valid <= wr_rot_end; // R21
			if (wr_rot_end) begin
				rot_end_ctrl <= data_in[7:5]; // R21
				target_level_bits <= data_in[2:0]; // R21
			end
		end
	end

	// special operation command: mask mode, read choice and poll
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			special_mask_mode <= 1'b0;
			status_read_sel <= PCP_SEL_PENDING;
			poll_armed <= 1'b0;
		end else if (init_start) begin
			special_mask_mode <= 1'b0; // R5
			status_read_sel <= PCP_SEL_PENDING; // R5
			poll_armed <= 1'b0;
		end else if (wr_special) begin
			if (data_in[OC3_SMM_ENABLE]) begin
				special_mask_mode <= data_in[OC3_SMM_SET]; // R22
			end
			if (data_in[OC3_READ_VALID]) begin
				status_read_sel <= data_in[OC3_READ_SEL] ? PCP_SEL_SERVICE : PCP_SEL_PENDING;
			end
			poll_armed <= data_in[OC3_POLL];
		end else if (rd_go && !port_select_line) begin
			// a poll answers one read only, then the old choice returns
			poll_armed <= 1'b0;
		end
	end

	// fetch data; the level choice is a poll, others follow the command
	assign next_read_data = port_select_line ? channel_mask_bits
		: poll_armed ? {5'h00, ack_level}
		: (status_read_sel == PCP_SEL_SERVICE) ? in_service_bits
		: pending_request_bits; // R7

	// read data and bus enable come from flops, one cycle behind the pins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= BYTE_ZERO;
			data_oe_n <= 1'b1;
		end else begin
			data_out <= next_read_data; // R7
			data_oe_n <= rd_n | chip_sel_n;
		end
	end

	// role: pin sampled as input unless buffered, then command four decides
	assign master_role = buffered_mode ? buffer_master_sel : spen_in; // R17
	assign spen_oe_n = ~buffered_mode; // R16
	// enable is active low and follows the data bus driver
	assign spen_out = buffered_mode ? data_oe_n : 1'b1; // R16

	// cascade: master names the slave, slave compares its identity
	assign cascade_match = ~master_role & (cascade_in == slave_identity); // R15
	assign cascade_oe_n = ~master_role;

	// acknowledge bytes registered so they stay steady through the pulse
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			call_byte <= BYTE_ZERO;
			addr_low_byte <= BYTE_ZERO;
			addr_high_byte <= BYTE_ZERO;
			vector16_byte <= BYTE_ZERO;
			ack_slave_supplies <= 1'b0;
			cascade_out <= LEVEL_ZERO;
		end else begin
			call_byte <= vf_call; // R14
			addr_low_byte <= vf_low; // R10
			addr_high_byte <= vf_high;
			vector16_byte <= vf_vec16; // R11
			ack_slave_supplies <= master_role & slave_equipped[ack_level]; // R14
			cascade_out <= ack_level;
		end
	end

	// checks beside the logic
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_init_mask; // R3
		init_start |=> channel_mask_bits == MASK_CLEAR;
	endproperty
	a_init_mask: assert property (p_init_mask) else $error("mask not cleared at init"); // R3

	property p_init_seven; // R4
		init_start |=> (slave_identity == LEVEL_SEVEN) && (lowest_priority_level == LEVEL_SEVEN);
	endproperty
	a_init_seven: assert property (p_init_seven) else $error("identity not seven"); // R4

	property p_init_modes; // R5
		init_start |=> !special_mask_mode && status_read_sel == PCP_SEL_PENDING && !poll_armed;
	endproperty
	a_init_modes: assert property (p_init_modes) else $error("modes not reset at init"); // R5

	property p_edge_pulse; // R2
		init_start |=> edge_sense_clear ##1 !edge_sense_clear;
	endproperty
	a_edge_pulse: assert property (p_edge_pulse) else $error("edge clear missing"); // R2

	property p_no_fourth; // R6
		init_start && !data_in[IC1_FOURTH_NEEDED] |=>
			!auto_end_of_service && !buffered_mode && !host_cpu_type && !special_nesting_sel;
	endproperty
	a_no_fourth: assert property (p_no_fourth) else $error("fourth settings not zero"); // R6

	property p_mask_load; // R20
		wr_high && ready |=> channel_mask_bits == $past(data_in);
	endproperty
	a_mask_load: assert property (p_mask_load) else $error("mask not loaded"); // R20

	property p_lone_skip; // R13
		wr_high && !init_start && seq_state == PCP_EXPECT_TWO && lone_controller_flag
			|=> seq_state != PCP_EXPECT_THREE;
	endproperty
	a_lone_skip: assert property (p_lone_skip) else $error("third command not skipped"); // R13

	property p_smm_hold; // R22
		wr_special && !data_in[OC3_SMM_ENABLE] |=> $stable(special_mask_mode);
	endproperty
	a_smm_hold: assert property (p_smm_hold) else $error("special mask changed"); // R22

	property p_role; // R17
		buffered_mode |-> master_role == buffer_master_sel && !spen_oe_n;
	endproperty
	a_role: assert property (p_role) else $error("buffered role wrong"); // R17

	property p_read_mask; // R7
		rd_go && port_select_line |=> data_out == $past(channel_mask_bits) ##0 !data_oe_n;
	endproperty
	a_read_mask: assert property (p_read_mask) else $error("mask read wrong"); // R7
endmodule : pcp_command_prog

// [hdl/pcp_pkg.sv]
// shared constants and types for the command programming front end
package pcp_pkg;
	// init command one field positions
	localparam int IC1_FOURTH_NEEDED = 0;
	localparam int IC1_LONE = 1;
	localparam int IC1_SPACING = 2;
	localparam int IC1_LEVEL_TRIG = 3;
	localparam int IC1_INIT_MARK = 4;
	// init command four field positions
	localparam int IC4_HOST_TYPE = 0;
	localparam int IC4_AUTO_END = 1;
	localparam int IC4_MASTER_SEL = 2;
	localparam int IC4_BUFFERED = 3;
	localparam int IC4_NESTING = 4;
	// operation command field positions
	localparam int OC_SPECIAL_MARK = 3;
	localparam int OC3_READ_SEL = 0;
	localparam int OC3_READ_VALID = 1;
	localparam int OC3_POLL = 2;
	localparam int OC3_SMM_SET = 5;
	localparam int OC3_SMM_ENABLE = 6;
	// reset and init values
	localparam logic [7:0] MASK_CLEAR = 8'h00;
	localparam logic [2:0] LEVEL_SEVEN = 3'h7;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [2:0] LEVEL_ZERO = 3'h0;
	// call opcode released on the first acknowledge of an 8-bit host
	localparam logic [7:0] CALL_OPCODE = 8'hCD;
	// initialization sequencer states
	typedef enum logic [2:0] {
		PCP_UNINIT,
		PCP_EXPECT_TWO,
		PCP_EXPECT_THREE,
		PCP_EXPECT_FOUR,
		PCP_READY
	} pcp_seq_t;
	// status read selection
	typedef enum logic [1:0] {
		PCP_SEL_PENDING,
		PCP_SEL_SERVICE,
		PCP_SEL_LEVEL
	} pcp_rdsel_t;
endpackage : pcp_pkg

// [hdl/pcp_strobe_edge.sv]
// start-of-strobe detector for an active-low host strobe
`timescale 1ns/1ps
module pcp_strobe_edge
	import pcp_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// host strobe and select
	input wire logic strobe_n,
	input wire logic chip_sel_n,
	// one-cycle pulse at the first low cycle
	output logic start
);
	logic strobe_prev_n; // strobe level one cycle back

	// remember the strobe so a held strobe starts only once
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_prev_n <= 1'b1;
		end else begin
			strobe_prev_n <= strobe_n;
		end
	end

	// a strobe already low at reset release is taken once, as strobe_prev_n resets high
	assign start = strobe_prev_n & ~strobe_n & ~chip_sel_n;
endmodule : pcp_strobe_edge

// [hdl/pcp_vector_format.sv]
// combinational builder of the acknowledge bytes for one level
`timescale 1ns/1ps
module pcp_vector_format
	import pcp_pkg::*;
(
	// programmed address parts
	input wire logic [2:0] addr_low_base,
	input wire logic [7:0] addr_high,
	input wire logic vector_spacing_sel,
	// level being acknowledged
	input wire logic [2:0] level,
	// bytes of the call sequence
	output logic [7:0] call_byte,
	output logic [7:0] addr_low_byte,
	output logic [7:0] addr_high_byte,
	// single byte of the 16-bit host
	output logic [7:0] vector16_byte
);
	logic [7:0] spaced_four; // four-byte spacing, low five bits inserted
	logic [7:0] spaced_eight; // eight-byte spacing, low six bits inserted

	assign call_byte = CALL_OPCODE;
	assign spaced_four = {addr_low_base, level, 2'b00}; // R10
	assign spaced_eight = {addr_low_base[2:1], level, 3'b000}; // R10
	assign addr_low_byte = vector_spacing_sel ? spaced_four : spaced_eight; // R10
	assign addr_high_byte = addr_high;
	// spacing and address bits 10..5 play no part here
	assign vector16_byte = {addr_high[7:3], level}; // R11
endmodule : pcp_vector_format

// [testbench/pcp_command_prog_test.sv]
// self-checking bench for the command programming front end
`timescale 1ns/1ps
module pcp_command_prog_test;
	import pcp_pkg::*;
	// stimulus owned by the bench
	logic ref_clk, rst_n, spen_in;
	logic [2:0] cascade_in, ack_level;
	logic [7:0] pending_request_bits, in_service_bits;
	// host bus
	logic chip_sel_n, rd_n, wr_n, port_select_line;
	logic [7:0] data_in, data_out, channel_mask_bits, slave_equipped;
	logic [7:0] call_byte, addr_low_byte, addr_high_byte, vector16_byte;
	// observed outputs
	logic data_oe_n, spen_out, spen_oe_n, cascade_oe_n, edge_sense_clear, edge_detect_enable;
	logic level_trigger_sel, lone_controller_flag, master_role, buffered_mode;
	logic auto_end_of_service, special_nesting_sel, host_cpu_type, special_mask_mode;
	logic init_done, rot_end_valid, ack_slave_supplies, cascade_match;
	logic [2:0] cascade_out, lowest_priority_level, slave_identity, rot_end_ctrl;
	logic [2:0] target_level_bits;
	// bookkeeping
	int err_total, checks_done, clr_seen, rot_seen;
	logic spen_act; // buffer enable seen while the data bus is driven
	logic [31:0] rng_state = 32'h000100C8;

	pcp_command_prog i_pcp_command_prog (
		.ref_clk(ref_clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n), .rd_n(rd_n), .wr_n(wr_n),
		.port_select_line(port_select_line), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n), .spen_in(spen_in), .spen_out(spen_out), .spen_oe_n(spen_oe_n),
		.cascade_in(cascade_in), .cascade_out(cascade_out), .cascade_oe_n(cascade_oe_n),
		.pending_request_bits(pending_request_bits), .in_service_bits(in_service_bits),
		.ack_level(ack_level), .channel_mask_bits(channel_mask_bits),
		.edge_sense_clear(edge_sense_clear), .edge_detect_enable(edge_detect_enable),
		.level_trigger_sel(level_trigger_sel), .lone_controller_flag(lone_controller_flag),
		.lowest_priority_level(lowest_priority_level), .slave_identity(slave_identity),
		.slave_equipped(slave_equipped), .master_role(master_role),
		.buffered_mode(buffered_mode), .auto_end_of_service(auto_end_of_service),
		.special_nesting_sel(special_nesting_sel), .host_cpu_type(host_cpu_type),
		.special_mask_mode(special_mask_mode), .init_done(init_done),
		.rot_end_valid(rot_end_valid), .rot_end_ctrl(rot_end_ctrl),
		.target_level_bits(target_level_bits), .call_byte(call_byte),
		.addr_low_byte(addr_low_byte), .addr_high_byte(addr_high_byte),
		.vector16_byte(vector16_byte), .ack_slave_supplies(ack_slave_supplies),
		.cascade_match(cascade_match)
	);

	pcp_host_model i_pcp_host_model (
		.ref_clk(ref_clk), .chip_sel_n(chip_sel_n), .rd_n(rd_n), .wr_n(wr_n),
		.port_select_line(port_select_line), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n)
	);

	// free-running bench clock, 8 ns period
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// pulse counters; a stuck pulse shows as a count above one
	always @(posedge ref_clk) begin
		if (edge_sense_clear === 1'b1) clr_seen++;
		if (rot_end_valid === 1'b1) rot_seen++;
		if (data_oe_n === 1'b0) spen_act = spen_out;
	end

	// xorshift source, fixed start so runs repeat
	function automatic logic [31:0] rnd();
		rng_state = rng_state ^ (rng_state << 13);
		rng_state = rng_state ^ (rng_state >> 17);
		rng_state = rng_state ^ (rng_state << 5);
		return rng_state;
	endfunction : rnd

	// expected low address byte of the call sequence
	function automatic logic [7:0] exp_low(input logic [7:0] ic1, input logic [2:0] lv);
		return ic1[IC1_SPACING] ? {ic1[7:5], lv, 2'h0} : {ic1[7:6], lv, 3'h0};
	endfunction : exp_low

	// single compare for every kind of result, narrow ones zero-extended
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// verdict and end of run
	task wrap_up();
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	// guard against a hung sequence
	initial begin
		repeat (100000) @(posedge ref_clk);
		err_total++;
		wrap_up();
	end

	// main sequence
	initial begin
		logic [7:0] ic1, ic2, ic3, ic4, d, m;
		logic [31:0] r;
		logic oe, mst;
		int c0;
		rst_n = 1'b0;
		spen_in = 1'b1;
		cascade_in = 3'h0;
		ack_level = 3'h0;
		pending_request_bits = 8'h00;
		in_service_bits = 8'h00;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		chk(channel_mask_bits, MASK_CLEAR);
		chk(slave_identity, LEVEL_SEVEN);
		chk(init_done, 8'h00);
		// mask store before any initialization is refused
		i_pcp_host_model.store(1'b1, 8'hFF);
		chk(channel_mask_bits, MASK_CLEAR);
		for (int k = 0; k < 8; k++) begin
			// random settings; k walks lone and fourth-needed flags and the rotate codes
			r = rnd();
			ic1 = {r[7:5], 1'b1, r[3:2], k[1:0]};
			ic2 = r[15:8];
			ic3 = r[23:16];
			ic4 = {3'h0, r[28:24]};
			@(posedge ref_clk);
			spen_in <= r[29];
			pending_request_bits <= r[31:24];
			in_service_bits <= r[23:16] ^ 8'h5A;
			// series given its first two bytes, then restarted by a fresh first command
			i_pcp_host_model.store(1'b0, ic1 ^ 8'hE0);
			i_pcp_host_model.store(1'b1, ~ic2);
			c0 = clr_seen;
			i_pcp_host_model.store(1'b0, ic1);
			chk(8'(clr_seen - c0), 8'h01);
			chk(channel_mask_bits, MASK_CLEAR);
			chk(lowest_priority_level, LEVEL_SEVEN);
			chk(slave_identity, LEVEL_SEVEN);
			chk(special_mask_mode, 8'h00);
			i_pcp_host_model.store(1'b1, ic2);
			if (!ic1[IC1_LONE]) i_pcp_host_model.store(1'b1, ic3);
			chk(init_done, !ic1[IC1_FOURTH_NEEDED]);
			if (ic1[IC1_FOURTH_NEEDED]) begin
				i_pcp_host_model.store(1'b1, ic4);
			end else begin
				// no fourth command: its settings must read as zero
				ic4 = 8'h00;
			end
			chk(init_done, 8'h01);
			chk(level_trigger_sel, ic1[IC1_LEVEL_TRIG]);
			chk(edge_detect_enable, !ic1[IC1_LEVEL_TRIG]);
			chk({special_nesting_sel, buffered_mode, auto_end_of_service, host_cpu_type},
				{ic4[4], ic4[3], ic4[1], ic4[0]});
			chk(slave_identity, ic1[IC1_LONE] ? LEVEL_SEVEN : ic3[2:0]);
			mst = ic4[IC4_BUFFERED] ? ic4[IC4_MASTER_SEL] : spen_in;
			chk(master_role, mst);
			chk(spen_oe_n, !ic4[IC4_BUFFERED]);
			// acknowledge level and cascade compare; half the passes drive the device's own id
			r = rnd();
			@(posedge ref_clk);
			ack_level <= r[2:0];
			cascade_in <= k[2] ? slave_identity : r[5:3];
			@(posedge ref_clk);
			@(negedge ref_clk);
			chk(cascade_match, !mst && cascade_in == slave_identity);
			chk(call_byte, CALL_OPCODE);
			chk(addr_low_byte, exp_low(ic1, r[2:0]));
			chk(addr_high_byte, ic2);
			chk(vector16_byte, {ic2[7:3], r[2:0]});
			if (!ic1[IC1_LONE]) chk(ack_slave_supplies, mst & ic3[r[2:0]]);
			// idle bus, cascade drive and copy of the level, lone flag
			chk({data_oe_n, cascade_oe_n, cascade_out, lone_controller_flag},
				{1'b1, !mst, r[2:0], ic1[IC1_LONE]});
			// status read points at pending bits after initialization
			i_pcp_host_model.fetch(1'b0, d, oe);
			chk(d, pending_request_bits);
			chk(oe, 8'h00);
			chk(spen_act, !ic4[IC4_BUFFERED]);
			// mask store and read-back on the high port
			m = r[15:8];
			i_pcp_host_model.store(1'b1, m);
			chk(channel_mask_bits, m);
			i_pcp_host_model.fetch(1'b1, d, oe);
			chk(d, m);
			// read selection via the special command, left on in-service
			i_pcp_host_model.store(1'b0, 8'h0A);
			i_pcp_host_model.fetch(1'b0, d, oe);
			chk(d, pending_request_bits);
			i_pcp_host_model.store(1'b0, 8'h0B);
			i_pcp_host_model.fetch(1'b0, d, oe);
			chk(d, in_service_bits);
			// poll answers one read with the level, then the old choice returns
			i_pcp_host_model.store(1'b0, 8'h0C);
			i_pcp_host_model.fetch(1'b0, d, oe);
			chk(d, {5'h00, r[2:0]});
			i_pcp_host_model.fetch(1'b0, d, oe);
			chk(d, in_service_bits);
			// special mask: set, ignored clear, real clear, set again for the next restart
			i_pcp_host_model.store(1'b0, 8'h68);
			chk(special_mask_mode, 8'h01);
			i_pcp_host_model.store(1'b0, 8'h08);
			chk(special_mask_mode, 8'h01);
			i_pcp_host_model.store(1'b0, 8'h48);
			chk(special_mask_mode, 8'h00);
			i_pcp_host_model.store(1'b0, 8'h68);
			// rotate/end command, one control code per pass
			d = {k[2:0], 2'h0, r[18:16]};
			c0 = rot_seen;
			i_pcp_host_model.store(1'b0, d);
			chk(rot_end_ctrl, k[2:0]);
			chk(target_level_bits, d[2:0]);
			chk(8'(rot_seen - c0), 8'h01);
		end
		wrap_up();
	end
endmodule : pcp_command_prog_test

// [testbench/pcp_host_model.sv]
// behavioural host processor driving the parallel command bus
`timescale 1ns/1ps
module pcp_host_model
	import pcp_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// bus toward the device
	output logic chip_sel_n,
	output logic rd_n,
	output logic wr_n,
	output logic port_select_line,
	output logic [7:0] data_in,
	// answer from the device
	input wire logic [7:0] data_out,
	input wire logic data_oe_n
);
	// idle bus at time zero
	initial begin
		chip_sel_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		port_select_line = 1'b0;
		data_in = 8'h00;
	end

	// one store cycle; strobe held across the taking edge, then a high cycle
	task store(input logic a, input logic [7:0] d);
		@(posedge ref_clk);
		chip_sel_n <= 1'b0;
		wr_n <= 1'b0;
		port_select_line <= a;
		data_in <= d;
		@(posedge ref_clk);
		@(posedge ref_clk);
		wr_n <= 1'b1;
		chip_sel_n <= 1'b1;
		// released data lines must not keep the old byte
		data_in <= ~d;
		@(negedge ref_clk);
	endtask : store

	// one fetch cycle; byte and drive enable taken at the same edge
	task fetch(input logic a, output logic [7:0] d, output logic oe_n);
		@(posedge ref_clk);
		chip_sel_n <= 1'b0;
		rd_n <= 1'b0;
		port_select_line <= a;
		@(posedge ref_clk);
		@(posedge ref_clk);
		d = data_out;
		oe_n = data_oe_n;
		rd_n <= 1'b1;
		chip_sel_n <= 1'b1;
		@(negedge ref_clk);
	endtask : fetch
endmodule : pcp_host_model
